// file: afr_clk_phase.sv
`timescale 1ns/1ns
module afr_clk_phase
  import afr_pkg::*;
(
  input  wire logic       i_clk,         // System clock.
  input  wire logic       i_resetn,      // Asynchronous reset, active low.
  input  wire logic [3:0] i_code,        // Phase field from the register.
  output logic            o_clk_out,     // Emitted output clock.
  output logic            o_frame_start, // One-cycle pulse at each data edge.
  output logic [3:0]      o_steps        // Applied phase in 60 degree steps.
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] rel;
  logic       clk_next;
  logic       start_next;
  logic [3:0] steps_next;

  always_comb begin
    cnt_next   = (cnt_reg == FRAME_TICKS - 5'h01) ? 5'h00 : cnt_reg + 5'h01;
    start_next = (cnt_reg == FRAME_TICKS - 5'h01);
    // Codes past the last step all land on one fixed offset.
    steps_next = (i_code > PHASE_LAST_CODE) ? PHASE_CLAMP_STEPS : i_code;
    // Clock rises a number of ticks after the data edge equal to the step count modulo six.
    rel = (cnt_reg >= {1'b0, o_steps}) ? cnt_reg - {1'b0, o_steps}
                                       : cnt_reg + FRAME_TICKS - {1'b0, o_steps};
    if (rel >= CLK_TICKS) begin
      rel = rel - CLK_TICKS;
    end
    clk_next = (rel < HIGH_TICKS);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg       <= 5'h00;
      o_clk_out     <= 1'b0;
      o_frame_start <= 1'b0;
      o_steps       <= RST_PHASE[3:0];
    end else begin
      cnt_reg       <= cnt_next;
      o_clk_out     <= clk_next;
      o_frame_start <= start_next;
      o_steps       <= steps_next;
    end
  end

endmodule : afr_clk_phase

// file: afr_pkg.sv
// Function
// - Coding 00 offset binary, 01 twos complement.
// - Phase code steps output clock 60 degrees.
// - Phase register resets to 0x03, 180 degrees.
// - Phase codes 1011 to 1111 give 660 degrees.
// - Pattern one bytes at 0x19/0x1A, reset zero.
// - Pattern two low byte at 0x1B, reset zero.
// - Pattern two high byte at 0x1C, reset zero.
package afr_pkg;

  localparam int unsigned SAMPLE_W = 16;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_FORMAT  = 6'h14;
  localparam logic [5:0] IDX_DRIVE   = 6'h15;
  localparam logic [5:0] IDX_PHASE   = 6'h16;
  localparam logic [5:0] IDX_PAT1_LO = 6'h19;
  localparam logic [5:0] IDX_PAT1_HI = 6'h1a;
  localparam logic [5:0] IDX_PAT2_LO = 6'h1b;
  localparam logic [5:0] IDX_PAT2_HI = 6'h1c;
  localparam logic [5:0] IDX_STATUS  = 6'h1d;

  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_DRIVE  = 8'h00;
  localparam logic [7:0] RST_PHASE  = 8'h03;
  localparam logic [7:0] RST_PAT    = 8'h00;

  // Field positions.
  localparam int unsigned FMT_LSB    = 0;
  localparam int unsigned INV_BIT    = 2;
  localparam int unsigned LOWPWR_BIT = 6;
  localparam int unsigned TERM_LSB   = 4;
  localparam int unsigned PHASE_LSB  = 0;

  localparam logic [1:0] CODE_OFFSET_BIN = 2'h0;
  localparam logic [1:0] CODE_TWOS       = 2'h1;

  // Output clock phase: one tick of i_clk is one 60 degree step.
  localparam int unsigned PHASE_STEP_DEG  = 60;
  localparam int unsigned PHASE_CLAMP_DEG = 660;
  localparam logic [3:0]  PHASE_LAST_CODE = 4'ha;
  localparam logic [3:0]  PHASE_CLAMP_STEPS = 4'(PHASE_CLAMP_DEG / PHASE_STEP_DEG);
  localparam logic [4:0]  FRAME_TICKS = 5'h0c;
  localparam logic [4:0]  CLK_TICKS   = 5'h06;
  localparam logic [4:0]  HIGH_TICKS  = 5'h03;

  typedef enum logic [1:0] {
    SRC_LIVE = 2'h0,
    SRC_PAT1 = 2'h1,
    SRC_PAT2 = 2'h2,
    SRC_ALT  = 2'h3
  } afr_src_e;

  typedef struct packed {
    logic [1:0]          coding;
    logic                invert;
    logic                low_power;
    logic [1:0]          term;
    logic [3:0]          phase;
    logic [SAMPLE_W-1:0] pat1;
    logic [SAMPLE_W-1:0] pat2;
  } afr_cfg_s;

endpackage : afr_pkg

// file: afr_regs.sv
`timescale 1ns/1ns
module afr_regs
  import afr_pkg::*;
(
  input  wire logic                i_clk,            // System clock, 50 MHz.
  input  wire logic                i_resetn,         // Asynchronous reset, active low.
  input  wire logic                i_wb_cyc,         // Wishbone cycle.
  input  wire logic                i_wb_stb,         // Wishbone strobe.
  input  wire logic                i_wb_we,          // Wishbone write enable.
  input  wire logic [7:0]          i_wb_adr,         // Wishbone byte address.
  input  wire logic [31:0]         i_wb_dat,         // Wishbone write data.
  input  wire logic [3:0]          i_wb_sel,         // Wishbone byte selects.
  output logic      [31:0]         o_wb_dat,         // Wishbone read data.
  output logic                     o_wb_ack,         // Wishbone acknowledge.
  input  wire logic [SAMPLE_W-1:0] i_sample,         // Live sample, offset binary.
  input  wire logic [1:0]          i_test_sel,       // Data source select.
  output logic      [SAMPLE_W-1:0] o_data,           // Emitted data word.
  output logic                     o_out_clk,        // Emitted output clock.
  output logic                     o_lvds_low_power, // Drive standard select.
  output logic      [1:0]          o_termination     // Drive termination select.
);

  afr_cfg_s            cfg_reg;
  afr_cfg_s            cfg_next;
  logic                ack_next;
  logic [31:0]         rdat_next;
  logic [SAMPLE_W-1:0] data_next;
  logic                alt_reg;
  logic                alt_next;
  logic                frame_start;
  logic [3:0]          steps;
  logic                req;
  logic                wr;
  logic [5:0]          idx;
  logic [7:0]          wbyte;
  logic [7:0]          rbyte;
  logic [SAMPLE_W-1:0] src;
  logic [SAMPLE_W-1:0] coded;
  afr_src_e            sel;

  afr_clk_phase u_clk_phase (
    .i_clk         (i_clk),
    .i_resetn      (i_resetn),
    .i_code        (cfg_reg.phase),
    .o_clk_out     (o_out_clk),
    .o_frame_start (frame_start),
    .o_steps       (steps)
  );

  // Register bank: a request is answered one cycle after it is seen, and
  // the ack is dropped in the following cycle so each access acks once.
  // A write lands at the edge where the master samples ack, so a request
  // that the master abandons before ack never alters a register.
  always_comb begin
    req      = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wr       = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0];
    idx      = i_wb_adr[7:2];
    wbyte    = i_wb_dat[7:0];
    cfg_next = cfg_reg;
    rbyte    = 8'h00;
    unique case (idx)
      IDX_FORMAT: begin
        rbyte[FMT_LSB +: 2]  = cfg_reg.coding;
        rbyte[INV_BIT]       = cfg_reg.invert;
        rbyte[LOWPWR_BIT]    = cfg_reg.low_power;
        if (wr) begin
          cfg_next.coding    = wbyte[FMT_LSB +: 2];
          cfg_next.invert    = wbyte[INV_BIT];
          cfg_next.low_power = wbyte[LOWPWR_BIT];
        end
      end
      IDX_DRIVE: begin
        rbyte[TERM_LSB +: 2] = cfg_reg.term;
        if (wr) begin
          cfg_next.term = wbyte[TERM_LSB +: 2];
        end
      end
      IDX_PHASE: begin
        rbyte[PHASE_LSB +: 4] = cfg_reg.phase;
        if (wr) begin
          cfg_next.phase = wbyte[PHASE_LSB +: 4];
        end
      end
      IDX_PAT1_LO: begin
        rbyte = cfg_reg.pat1[7:0];
        if (wr) begin
          cfg_next.pat1[7:0] = wbyte;
        end
      end
      IDX_PAT1_HI: begin
        rbyte = cfg_reg.pat1[15:8];
        if (wr) begin
          cfg_next.pat1[15:8] = wbyte;
        end
      end
      IDX_PAT2_LO: begin
        rbyte = cfg_reg.pat2[7:0];
        if (wr) begin
          cfg_next.pat2[7:0] = wbyte;
        end
      end
      IDX_PAT2_HI: begin
        rbyte = cfg_reg.pat2[15:8];
        if (wr) begin
          cfg_next.pat2[15:8] = wbyte;
        end
      end
      IDX_STATUS: begin
        rbyte = {3'h0, o_out_clk, steps};
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
    ack_next  = req;
    rdat_next = (req && !i_wb_we) ? {24'h00_0000, rbyte} : 32'h0000_0000;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg.coding    <= RST_FORMAT[FMT_LSB +: 2];
      cfg_reg.invert    <= RST_FORMAT[INV_BIT];
      cfg_reg.low_power <= RST_FORMAT[LOWPWR_BIT];
      cfg_reg.term      <= RST_DRIVE[TERM_LSB +: 2];
      cfg_reg.phase     <= RST_PHASE[PHASE_LSB +: 4];
      cfg_reg.pat1      <= {RST_PAT, RST_PAT};
      cfg_reg.pat2      <= {RST_PAT, RST_PAT};
      o_wb_ack          <= 1'b0;
      o_wb_dat          <= 32'h0000_0000;
    end else begin
      cfg_reg  <= cfg_next;
      o_wb_ack <= ack_next;
      o_wb_dat <= rdat_next;
    end
  end

  // Data path: source choice, then coding, then polarity. Test patterns go
  // through the same coding so software sees them as it would live data.
  always_comb begin
    sel = afr_src_e'(i_test_sel);
    unique case (sel)
      SRC_LIVE: src = i_sample;
      SRC_PAT1: src = cfg_reg.pat1;
      SRC_PAT2: src = cfg_reg.pat2;
      SRC_ALT:  src = alt_reg ? cfg_reg.pat2 : cfg_reg.pat1;
    endcase
    // Unused coding codes fall back to offset binary.
    if (cfg_reg.coding == CODE_TWOS) begin
      coded = {~src[SAMPLE_W-1], src[SAMPLE_W-2:0]};
    end else begin
      coded = src;
    end
    alt_next  = alt_reg;
    data_next = o_data;
    if (frame_start) begin
      alt_next  = !alt_reg;
      data_next = coded ^ {SAMPLE_W{cfg_reg.invert}};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      alt_reg          <= 1'b0;
      o_data           <= '0;
      o_lvds_low_power <= 1'b0;
      o_termination    <= 2'h0;
    end else begin
      alt_reg          <= alt_next;
      o_data           <= data_next;
      o_lvds_low_power <= cfg_reg.low_power;
      o_termination    <= cfg_reg.term;
    end
  end

endmodule : afr_regs

// file: afr_regs_bench.sv
`timescale 1ns/1ns
module afr_regs_bench;
  import afr_pkg::*;
  logic        i_clk, i_resetn, cyc, stb, we, o_wb_ack, o_out_clk, o_lp, last_c;
  logic [7:0]  adr;
  logic [31:0] wdat, o_wb_dat, seed, q, r;
  logic [3:0]  sel;
  logic [15:0] smp, o_data, exp_d, last_d, p1, p2;
  logic [1:0]  tsel, o_term;
  int          miscompares, n_compared, cycles, t_d, t_c, mdl[64];

  afr_regs dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_sample(smp), .i_test_sel(tsel), .o_data(o_data),
    .o_out_clk(o_out_clk), .o_lvds_low_power(o_lp), .o_termination(o_term));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function logic [7:0] msk(input logic [5:0] ix);
    case (ix)
      IDX_FORMAT: return 8'h47;
      IDX_DRIVE:  return 8'h30;
      IDX_PHASE:  return 8'h0f;
      IDX_PAT1_LO, IDX_PAT1_HI, IDX_PAT2_LO, IDX_PAT2_HI: return 8'hff;
      default:    return 8'h00;
    endcase
  endfunction : msk

  // Applies the modelled coding and polarity to a source word.
  function logic [15:0] cod(input logic [15:0] v);
    logic [15:0] w;
    w = v;
    if ((mdl[IDX_FORMAT] & 3) == 1) w ^= 16'h8000;
    if ((mdl[IDX_FORMAT] & 4) != 0) w = ~w;
    return w;
  endfunction : cod

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  // The master holds every request signal until it samples ack high.
  task wb(input logic w, input logic [5:0] ix, input logic [7:0] d, input logic s0);
    int n;
    @(posedge i_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {ix, 2'h0};
    wdat <= {r[31:24], 16'h0000, d};
    sel  <= {3'h7, s0};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w && s0) mdl[ix] = d & msk(ix);
  endtask : wb

  task rd_chk(input logic [5:0] ix);
    logic [3:0] st;
    wb(1'b0, ix, 8'h00, 1'b1);
    st = (mdl[IDX_PHASE] > 10) ? 4'hb : 4'(mdl[IDX_PHASE]);
    if (ix == IDX_STATUS) chk("steps", {28'h000_0000, st}, {28'h000_0000, q[3:0]});
    else chk("register", 32'(mdl[ix]), q);
  endtask : rd_chk

  task results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Hanging anywhere ends the run well past the expected few thousand cycles.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  always @(posedge i_clk) begin
    #1;
    if (o_data !== last_d) t_d = cycles;
    if (o_out_clk && !last_c) t_c = cycles;
    last_d = o_data;
    last_c = o_out_clk;
  end

  initial begin
    seed = 32'h0001_6cae;
    {i_resetn, cyc, stb, we, adr, wdat, sel, smp, tsel, r} = '0;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[IDX_PHASE] = 3;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int i = 16; i < 32; i++) rd_chk(6'(i));
    repeat (40) begin
      r = rnd();
      wb(1'b1, 6'(16 + r[3:0]), r[15:8], r[16]);
      rd_chk(6'(16 + r[3:0]));
    end
    for (int i = 25; i < 29; i++) begin
      r = rnd();
      wb(1'b1, 6'(i), r[7:0], 1'b1);
    end
    smp <= r[31:16];
    for (int s = 0; s < 3; s++) for (int f = 0; f < 8; f++) begin
      r = rnd();
      tsel <= 2'(s);
      wb(1'b1, IDX_FORMAT, {1'b0, r[6], 3'h0, 3'(f)}, 1'b1);
      wb(1'b1, IDX_DRIVE, r[15:8], 1'b1);
      repeat (26) @(posedge i_clk);
      exp_d = (s == 0) ? smp : 16'(mdl[IDX_PAT1_HI + 2 * s - 2] * 256 + mdl[IDX_PAT1_LO + 2 * s - 2]);
      if (f % 4 == 1) exp_d ^= 16'h8000;
      if (f > 3) exp_d = ~exp_d;
      chk("data", {16'h0000, exp_d}, {16'h0000, o_data});
      chk("low power", 32'(mdl[IDX_FORMAT] >> 6), {31'h0, o_lp});
      chk("termination", 32'(mdl[IDX_DRIVE] >> 4), {30'h0, o_term});
    end
    tsel <= 2'h3;
    wb(1'b1, IDX_PAT2_LO, ~8'(mdl[IDX_PAT1_LO]), 1'b1);
    for (int k = 0; k < 16; k++) begin
      wb(1'b1, IDX_PHASE, 8'(k), 1'b1);
      rd_chk(IDX_STATUS);
      repeat (30) @(posedge i_clk);
      do begin
        @(posedge i_clk);
        #2;
      end while (t_d != cycles);
      repeat (5) @(posedge i_clk);
      #2;
      chk("clock lag", 32'((k > 10 ? 11 : k) % 6), 32'(t_c - t_d));
      p1 = cod(16'(mdl[IDX_PAT1_HI] * 256 + mdl[IDX_PAT1_LO]));
      p2 = cod(16'(mdl[IDX_PAT2_HI] * 256 + mdl[IDX_PAT2_LO]));
      chk("pattern word", 32'h0000_0001, 32'(o_data == p1 || o_data == p2));
      exp_d = (o_data == p1) ? p2 : p1;
      repeat (12) @(posedge i_clk);
      #2;
      chk("alternate word", {16'h0000, exp_d}, {16'h0000, o_data});
    end
    results();
  end
endmodule : afr_regs_bench

// file: afr_regs_monitor.sv
`timescale 1ns/1ns
module afr_regs_monitor
  import afr_pkg::*;
(
  input wire logic                i_clk,            // Clock.
  input wire logic                i_resetn,         // Reset.
  input wire logic                i_wb_cyc,         // Cycle.
  input wire logic                i_wb_stb,         // Strobe.
  input wire logic                i_wb_we,          // Write.
  input wire logic [7:0]          i_wb_adr,         // Address.
  input wire logic [31:0]         i_wb_dat,         // Write data.
  input wire logic [3:0]          i_wb_sel,         // Selects.
  input wire logic [31:0]         o_wb_dat,         // Read data.
  input wire logic                o_wb_ack,         // Ack.
  input wire logic [SAMPLE_W-1:0] o_data,           // Data word.
  input wire logic                o_lvds_low_power  // Drive mode.
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd(logic [5:0] ix);
    i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && i_wb_adr[7:2] == ix;
  endsequence
  sequence s_wr(logic [5:0] ix);
    i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == ix;
  endsequence
  a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_rdata_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data without ack");
  a_rdata_byte: assert property (o_wb_dat[31:8] == 24'h00_0000)
    else $error("read data above byte");
  a_format_bits: assert property (s_rd(IDX_FORMAT) |=> (o_wb_dat[7:0] & 8'hb8) == 8'h00)
    else $error("format unused bits set");
  a_phase_bits: assert property (s_rd(IDX_PHASE) |=> o_wb_dat[7:4] == 4'h0)
    else $error("phase unused bits set");
  a_status_clamp: assert property (s_rd(IDX_STATUS) |=> o_wb_dat[3:0] <= 4'hb)
    else $error("phase steps above clamp");
  a_low_power: assert property (s_wr(IDX_FORMAT) |-> ##3 o_lvds_low_power == $past(i_wb_dat[6], 3))
    else $error("low power copy wrong");
  a_data_stands: assert property ($changed(o_data) |=> $stable(o_data)[*8])
    else $error("data word changed within frame");
endmodule : afr_regs_monitor

bind afr_regs afr_regs_monitor mon_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_data(o_data),
  .o_lvds_low_power(o_lvds_low_power));
